/* tgc_pkg.sv */
package tgc_pkg;

  // register indices on the plain register port
  localparam logic [2:0] TGC_ADDR_TCTL = 3'h0;
  localparam logic [2:0] TGC_ADDR_GCTL = 3'h1;
  localparam logic [2:0] TGC_ADDR_CNTH = 3'h2;
  localparam logic [2:0] TGC_ADDR_CNTL = 3'h3;
  localparam logic [2:0] TGC_ADDR_ISTAT = 3'h4;
  localparam logic [2:0] TGC_ADDR_IMASK = 3'h5;

  // timer_control fields
  localparam int TGC_TCTL_RUN = 0;
  localparam logic [7:0] TGC_TCTL_MASK = 8'hFD;

  // gate_control fields
  localparam int TGC_GCTL_GE = 7;
  localparam int TGC_GCTL_POL = 6;
  localparam int TGC_GCTL_TM = 5;
  localparam int TGC_GCTL_SPM = 4;
  localparam int TGC_GCTL_GO = 3;
  localparam int TGC_GCTL_VAL = 2;
  localparam int TGC_GCTL_SS_HI = 1;
  localparam int TGC_GCTL_SS_LO = 0;
  localparam logic [7:0] TGC_GCTL_WMASK = 8'hF3;

  // gate source selection codes
  localparam logic [1:0] TGC_SRC_PIN = 2'h0;
  localparam logic [1:0] TGC_SRC_TOVF = 2'h1;
  localparam logic [1:0] TGC_SRC_CMP1 = 2'h2;
  localparam logic [1:0] TGC_SRC_CMP2 = 2'h3;

  // interrupt status bit for gate event
  localparam int TGC_IRQ_GATE = 0;
  localparam logic [7:0] TGC_IRQ_MASK = 8'h01;

  localparam logic [7:0] TGC_RST_BYTE = 8'h00;
  localparam logic [15:0] TGC_RST_COUNT = 16'h0000;
  localparam logic [15:0] TGC_COUNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    TGC_SP_IDLE,
    TGC_SP_WAIT_EDGE,
    TGC_SP_ACTIVE
  } tgc_sp_state_t;

endpackage : tgc_pkg

/* tgc_gate_source.sv */
`timescale 1ns/10ps
module tgc_gate_source
  import tgc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // selection and shaping
  input wire logic [1:0] sel,
  input wire logic pol,
  input wire logic toggle_en,
  // gate sources
  input wire logic src_pin,
  input wire logic src_tovf,
  input wire logic src_cmp1,
  input wire logic src_cmp2,
  // shaped gate level and rising edge of the active level
  output logic gate_level,
  output logic gate_rise
);

  logic raw;
  logic raw_d;
  logic tff;
  logic next_raw_d;
  logic next_tff;
  logic polar;

  // source mux and polarity; active level counted as one
  always_comb begin
    unique case (sel)
      TGC_SRC_PIN: raw = src_pin;
      TGC_SRC_TOVF: raw = src_tovf;
      TGC_SRC_CMP1: raw = src_cmp1;
      TGC_SRC_CMP2: raw = src_cmp2;
    endcase
    polar = pol ? raw : ~raw;
    next_raw_d = polar;
    // toggle on each rising edge, held clear when mode is off
    if (!toggle_en) begin
      next_tff = 1'b0;
    end else if (polar && !raw_d) begin
      next_tff = ~tff;
    end else begin
      next_tff = tff;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    // start at the idle level (low sources, low polarity) so no false rise follows reset
    if (!arst_n) begin
      raw_d <= 1'b1;
      tff <= 1'b0;
    end else begin
      raw_d <= next_raw_d;
      tff <= next_tff;
    end
  end

  // toggle mode passes the flip-flop, otherwise the level itself
  assign gate_level = toggle_en ? tff : polar;
  assign gate_rise = polar && !raw_d;

  a_toggle_cleared: assert property (@(posedge clk) disable iff (!arst_n)
    !toggle_en |=> !tff)
    else $error("toggle flip-flop not cleared");
  a_toggle_flips: assert property (@(posedge clk) disable iff (!arst_n)
    toggle_en && $past(toggle_en) && polar && !raw_d |=> tff != $past(tff))
    else $error("toggle flip-flop missed an edge");

endmodule : tgc_gate_source

/* tgc_single_pulse.sv */
`timescale 1ns/10ps
module tgc_single_pulse
  import tgc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic spm_en,
  input wire logic arm,
  input wire logic gate_level,
  input wire logic gate_rise,
  // status
  output logic go_done,
  output logic sp_gate,
  output logic done_pulse
);

  tgc_sp_state_t state;
  tgc_sp_state_t next_state;
  logic next_done;
  logic done_q;

  // armed waits for a rising edge, counts one active phase, then finishes
  always_comb begin
    next_state = state;
    next_done = 1'b0;
    if (!spm_en) begin
      next_state = TGC_SP_IDLE; // mode off: no control
    end else begin
      unique case (state)
        TGC_SP_IDLE: if (arm) next_state = TGC_SP_WAIT_EDGE;
        TGC_SP_WAIT_EDGE: if (gate_rise) next_state = TGC_SP_ACTIVE;
        TGC_SP_ACTIVE: if (!gate_level) begin
          next_state = TGC_SP_IDLE;
          next_done = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= TGC_SP_IDLE;
      done_q <= 1'b0;
    end else begin
      state <= next_state;
      done_q <= next_done;
    end
  end

  // go/done reads one while armed or acquiring, zero otherwise
  assign go_done = (state != TGC_SP_IDLE);
  assign sp_gate = (state == TGC_SP_ACTIVE) && gate_level;
  assign done_pulse = done_q;

  a_done_clears: assert property (@(posedge clk) disable iff (!arst_n)
    state == TGC_SP_ACTIVE && spm_en && !gate_level |=> !go_done ##0 done_pulse)
    else $error("go/done not cleared on completion");
  a_idle_zero: assert property (@(posedge clk) disable iff (!arst_n)
    !spm_en |=> !go_done && !sp_gate)
    else $error("go/done set while mode disabled");

endmodule : tgc_single_pulse

/* tgc_top.sv */
`timescale 1ns/10ps
module tgc_top
  import tgc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // gate sources
  input wire logic GATE_PIN,
  input wire logic TIMER_OVF,
  input wire logic CMP_ONE_SYNC_OUT,
  input wire logic CMP_TWO_SYNC_OUT,
  // counter clock tick from the prescaler
  input wire logic COUNT_TICK,
  // status outputs
  output logic COUNT_ENABLE,
  output logic IRQ
);

  logic [7:0] timer_control;
  logic [7:0] gate_control;
  logic [15:0] main_count;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] next_timer_control;
  logic [7:0] next_gate_control;
  logic [15:0] next_main_count;
  logic [7:0] next_irq_status;
  logic [7:0] next_irq_mask;
  logic [7:0] next_rdata;
  logic gate_level;
  logic gate_rise;
  logic go_done;
  logic sp_gate;
  logic done_pulse;
  logic timer_run;
  logic gate_enable_ctl;
  logic gate_single_pulse_mode;
  logic gate_level_now;
  logic count_ok;
  logic arm;

  assign timer_run = timer_control[TGC_TCTL_RUN];
  assign gate_enable_ctl = gate_control[TGC_GCTL_GE];
  assign gate_single_pulse_mode = gate_control[TGC_GCTL_SPM];
  // software arms by writing a one to go/done
  assign arm = WR && (ADDR == TGC_ADDR_GCTL) && WDATA[TGC_GCTL_GO];

  tgc_gate_source tgc_gate_source_i (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .sel(gate_control[TGC_GCTL_SS_HI:TGC_GCTL_SS_LO]),
    .pol(gate_control[TGC_GCTL_POL]),
    .toggle_en(gate_control[TGC_GCTL_TM]),
    .src_pin(GATE_PIN),
    .src_tovf(TIMER_OVF),
    .src_cmp1(CMP_ONE_SYNC_OUT),
    .src_cmp2(CMP_TWO_SYNC_OUT),
    .gate_level(gate_level),
    .gate_rise(gate_rise)
  );

  // mode is seen as it is being written, so one write can enable and arm
  tgc_single_pulse tgc_single_pulse_i (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .spm_en(next_gate_control[TGC_GCTL_SPM]),
    .arm(arm),
    .gate_level(gate_level),
    .gate_rise(gate_rise),
    .go_done(go_done),
    .sp_gate(sp_gate),
    .done_pulse(done_pulse)
  );

  // single-pulse logic only steers the gate when its mode is on
  assign gate_level_now = gate_single_pulse_mode ? sp_gate : gate_level;

  // gate enable ignored when stopped; free run when enable clear
  assign count_ok = timer_run && (!gate_enable_ctl || gate_level_now);
  assign COUNT_ENABLE = count_ok;
  assign IRQ = |(irq_status & irq_mask);

  // register writes, counting and event capture
  always_comb begin
    next_timer_control = timer_control;
    next_gate_control = gate_control;
    next_main_count = main_count;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (count_ok && COUNT_TICK) begin
      next_main_count = main_count + TGC_COUNT_ONE;
    end
    if (WR) begin
      unique case (ADDR)
        TGC_ADDR_TCTL: next_timer_control = WDATA & TGC_TCTL_MASK;
        TGC_ADDR_GCTL: next_gate_control = WDATA & TGC_GCTL_WMASK;
        TGC_ADDR_CNTH: next_main_count[15:8] = WDATA;
        TGC_ADDR_CNTL: next_main_count[7:0] = WDATA;
        TGC_ADDR_ISTAT: next_irq_status = irq_status & ~WDATA;
        TGC_ADDR_IMASK: next_irq_mask = WDATA & TGC_IRQ_MASK;
        default: ;
      endcase
    end
    // set beats a same-cycle clear so no completion is lost
    if (done_pulse) begin
      next_irq_status[TGC_IRQ_GATE] = 1'b1;
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    next_rdata = TGC_RST_BYTE;
    if (RD) begin
      unique case (ADDR)
        TGC_ADDR_TCTL: next_rdata = timer_control;
        TGC_ADDR_GCTL: begin
          next_rdata = gate_control;
          next_rdata[TGC_GCTL_GO] = go_done;
          next_rdata[TGC_GCTL_VAL] = gate_level_now;
        end
        TGC_ADDR_CNTH: next_rdata = main_count[15:8];
        TGC_ADDR_CNTL: next_rdata = main_count[7:0];
        TGC_ADDR_ISTAT: next_rdata = irq_status;
        TGC_ADDR_IMASK: next_rdata = irq_mask;
        default: next_rdata = TGC_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      timer_control <= TGC_RST_BYTE;
      gate_control <= TGC_RST_BYTE;
      main_count <= TGC_RST_COUNT;
      irq_status <= TGC_RST_BYTE;
      irq_mask <= TGC_RST_BYTE;
      RDATA <= TGC_RST_BYTE;
    end else begin
      timer_control <= next_timer_control;
      gate_control <= next_gate_control;
      main_count <= next_main_count;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      RDATA <= next_rdata;
    end
  end

  a_stopped_no_count: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !timer_run |-> !COUNT_ENABLE)
    else $error("counting while timer stopped");
  a_free_run: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    timer_run && !gate_enable_ctl |-> COUNT_ENABLE)
    else $error("free run blocked");
  a_gate_follows: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    timer_run && gate_enable_ctl |-> COUNT_ENABLE == gate_level_now)
    else $error("count enable does not follow gate");
  a_count_steps: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    COUNT_ENABLE && COUNT_TICK && !WR |=> main_count == $past(main_count) + TGC_COUNT_ONE)
    else $error("counter did not advance");
  a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    RD && ADDR == TGC_ADDR_TCTL |=> RDATA[1] == 1'b0)
    else $error("unimplemented bit read nonzero");
  a_val_reads: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    RD && ADDR == TGC_ADDR_GCTL |=> RDATA[TGC_GCTL_VAL] == $past(gate_level_now))
    else $error("gate level bit wrong");
  a_event_flag: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    done_pulse |=> irq_status[TGC_IRQ_GATE])
    else $error("gate event flag not raised");
  // a one written to the status bit clears it unless an event lands in the same cycle
  a_status_w1c: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    WR && ADDR == TGC_ADDR_ISTAT && WDATA[TGC_IRQ_GATE] && !done_pulse
      |=> !irq_status[TGC_IRQ_GATE])
    else $error("gate event flag not cleared by write");

  c_sp_done: cover property (@(posedge REF_CLK) disable iff (!ARST_N) done_pulse);
  c_sp_armed: cover property (@(posedge REF_CLK) disable iff (!ARST_N)
    go_done && !gate_level_now);
  c_gated_count: cover property (@(posedge REF_CLK) disable iff (!ARST_N)
    gate_enable_ctl && COUNT_ENABLE && COUNT_TICK);
  c_irq: cover property (@(posedge REF_CLK) disable iff (!ARST_N) IRQ);

endmodule : tgc_top

/* tgc_gate_model.sv */
`timescale 1ns/10ps
module tgc_gate_model
  import tgc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // wanted levels: pin, overflow, cmp one, cmp two
  input wire logic [3:0] want,
  // source levels seen by the block
  output logic pin,
  output logic tovf,
  output logic cmp1,
  output logic cmp2
);
  // sources move only after an edge, since the block takes them as synchronous
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {cmp2, cmp1, tovf, pin} <= 4'h0;
    end else begin
      {cmp2, cmp1, tovf, pin} <= want;
    end
  end
endmodule : tgc_gate_model

/* test_timer_gate_control.sv */
`timescale 1ns/10ps
module test_timer_gate_control
  import tgc_pkg::*;
;
  logic ref_clk, arst_n, wr, rd, tick, pin, tovf, c1, c2, cen, irq, p, l, v;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [3:0] want, m;
  logic [1:0] s;
  int fail_count, cmp_count;

  // far side of the gate inputs
  tgc_gate_model tgc_gate_model_i (.clk(ref_clk), .arst_n(arst_n), .want(want),
    .pin(pin), .tovf(tovf), .cmp1(c1), .cmp2(c2));
  tgc_top tgc_top_i (.REF_CLK(ref_clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .GATE_PIN(pin), .TIMER_OVF(tovf),
    .CMP_ONE_SYNC_OUT(c1), .CMP_TWO_SYNC_OUT(c2), .COUNT_TICK(tick),
    .COUNT_ENABLE(cen), .IRQ(irq));

  // clock at 125 MHz
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] val);
    @(posedge ref_clk);
    addr <= a;
    wdata <= val;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask : rd_chk

  // model registers the sources, shaping may add a stage: allow a few edges
  task automatic src(input logic [3:0] val);
    @(posedge ref_clk);
    want <= val;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : src

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // whole run is well under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    {arst_n, wr, rd, tick, addr, wdata, want} = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    // reset values; live gate bit is high: low pin under low polarity
    for (int a = 0; a < 8; a++) begin
      rd_chk("reset", a[2:0], (a == 1) ? 8'h04 : 8'h00);
    end
    wr_reg(TGC_ADDR_TCTL, 8'hFF);
    rd_chk("tctl", TGC_ADDR_TCTL, TGC_TCTL_MASK);
    wr_reg(TGC_ADDR_IMASK, 8'hFF);
    rd_chk("imask", TGC_ADDR_IMASK, 8'h01);
    wr_reg(3'h6, 8'hFF);
    rd_chk("unmapped", 3'h6, 8'h00);
    $display("test registers done");
    // gate enable ignored while stopped, free count when gate disabled
    wr_reg(TGC_ADDR_TCTL, 8'h00);
    wr_reg(TGC_ADDR_GCTL, 8'h80);
    src(4'h0);
    chk("cen off", {7'h00, cen}, 8'h00);
    wr_reg(TGC_ADDR_TCTL, 8'h01);
    // every source, polarity and level; gate enable follows source bit 1
    for (int i = 0; i < 16; i++) begin
      s = i[3:2];
      p = i[1];
      l = i[0];
      v = (l == p);
      m = 4'h1 << s;
      wr_reg(TGC_ADDR_GCTL, {s[1], p, 4'h0, s});
      src(l ? m : ~m);
      chk("cen src", {7'h00, cen}, {7'h00, !s[1] || v});
      rd_chk("gate level", TGC_ADDR_GCTL, {s[1], p, 3'h0, v, s});
    end
    $display("test sources done");
    // toggle flip-flop starts cleared and flips on rises only
    src(4'h0);
    wr_reg(TGC_ADDR_GCTL, 8'hE0);
    src(4'h0);
    chk("tog0", {7'h00, cen}, 8'h00);
    src(4'h1);
    chk("tog1", {7'h00, cen}, 8'h01);
    src(4'h0);
    chk("tog2", {7'h00, cen}, 8'h01);
    src(4'h1);
    chk("tog3", {7'h00, cen}, 8'h00);
    wr_reg(TGC_ADDR_GCTL, 8'hC0);
    src(4'h1);
    chk("direct", {7'h00, cen}, 8'h01);
    $display("test toggle done");
    // single pulse: arm, one high phase counts, then done and event
    src(4'h0);
    wr_reg(TGC_ADDR_GCTL, 8'hD8);
    rd_chk("armed", TGC_ADDR_GCTL, 8'hD8);
    chk("sp wait", {7'h00, cen}, 8'h00);
    src(4'h1);
    chk("sp high", {7'h00, cen}, 8'h01);
    src(4'h0);
    rd_chk("done", TGC_ADDR_GCTL, 8'hD0);
    rd_chk("istat", TGC_ADDR_ISTAT, 8'h01);
    chk("irq", {7'h00, irq}, 8'h01);
    src(4'h1);
    chk("sp once", {7'h00, cen}, 8'h00);
    wr_reg(TGC_ADDR_IMASK, 8'h00);
    rd_chk("masked", TGC_ADDR_ISTAT, 8'h01);
    chk("irq mask", {7'h00, irq}, 8'h00);
    wr_reg(TGC_ADDR_IMASK, 8'h01);
    wr_reg(TGC_ADDR_ISTAT, 8'h01);
    rd_chk("cleared", TGC_ADDR_ISTAT, 8'h00);
    chk("irq clr", {7'h00, irq}, 8'h00);
    $display("test single pulse done");
    // byte access and carry from low into high byte
    wr_reg(TGC_ADDR_GCTL, 8'h00);
    wr_reg(TGC_ADDR_CNTH, 8'h12);
    wr_reg(TGC_ADDR_CNTL, 8'hFF);
    rd_chk("cnt h", TGC_ADDR_CNTH, 8'h12);
    rd_chk("cnt l", TGC_ADDR_CNTL, 8'hFF);
    @(posedge ref_clk);
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    rd_chk("inc h", TGC_ADDR_CNTH, 8'h13);
    rd_chk("inc l", TGC_ADDR_CNTL, 8'h00);
    $display("test count done");
    wrap_up();
  end
endmodule : test_timer_gate_control
